/* shared/plk_pkg.sv */
package plk_pkg;
  // control pair codes while the phy owns the pair
  localparam logic [1:0] CTL_IDLE = 2'h0;
  localparam logic [1:0] CTL_STATUS = 2'h1;
  localparam logic [1:0] CTL_RECEIVE = 2'h2;
  localparam logic [1:0] CTL_GRANT = 2'h3;
  // control pair codes while the link owns the pair (2'h3 is never driven)
  localparam logic [1:0] CTL_RELEASE = 2'h0;
  localparam logic [1:0] CTL_HOLD = 2'h1;
  localparam logic [1:0] CTL_XMIT = 2'h2;

  // request type field
  localparam logic [2:0] TYPE_IMM = 3'h0;
  localparam logic [2:0] TYPE_ISO = 3'h1;
  localparam logic [2:0] TYPE_PRI = 3'h2;
  localparam logic [2:0] TYPE_FAIR = 3'h3;
  localparam logic [2:0] TYPE_REG_READ = 3'h4;
  localparam logic [2:0] TYPE_REG_WRITE = 3'h5;
  localparam logic [2:0] TYPE_ACCEL = 3'h6;
  localparam logic [2:0] TYPE_RESERVED = 3'h7;

  // speed field
  localparam logic [2:0] SPD_S100 = 3'h0;
  localparam logic [2:0] SPD_S200 = 3'h2;
  localparam logic [2:0] SPD_S400 = 3'h4;

  // request stream layout, bit 0 sits at the msb of the vector
  localparam int STREAM_W = 17;
  localparam int LEN_W = 5;
  localparam int STREAM_TYPE_LSB = 13;
  localparam int STREAM_SPD_LSB = 10;
  localparam logic START_BIT = 1'b1;
  localparam logic STOP_BIT = 1'b0;
  localparam logic [4:0] LEN_BUS_SHORT = 5'h07;
  localparam logic [4:0] LEN_BUS_LONG = 5'h08;
  localparam logic [4:0] LEN_READ = 5'h09;
  localparam logic [4:0] LEN_WRITE = 5'h11;
  localparam logic [4:0] LEN_ACCEL = 5'h06;

  // data lanes per speed and index of the last beat of a byte
  localparam logic [3:0] LANES_S100 = 4'h2;
  localparam logic [3:0] LANES_S200 = 4'h4;
  localparam logic [3:0] LANES_S400 = 4'h8;
  localparam logic [3:0] LANES_ALL = 4'h8;
  localparam logic [1:0] LAST_BEAT_S100 = 2'h3;
  localparam logic [1:0] LAST_BEAT_S200 = 2'h1;
  localparam logic [1:0] LAST_BEAT_S400 = 2'h0;

  // ownership of the control pair and data bus
  typedef enum logic [1:0] {
    OWN_PHY = 2'b00,
    OWN_HOLD = 2'b01,
    OWN_XMIT = 2'b10,
    OWN_RELEASE = 2'b11
  } plk_own_t;

  // request stream sender
  typedef enum logic {
    RQ_IDLE = 1'b0,
    RQ_SEND = 1'b1
  } plk_rq_t;
endpackage

/* shared/plk_req_if.sv */
`timescale 1ns/10ps
`default_nettype none

// one request stream handed to the serialiser
interface plk_req_if;
  logic load;
  logic [plk_pkg::STREAM_W-1:0] stream;
  logic [plk_pkg::LEN_W-1:0] len;
  logic busy;
  modport src (output load, output stream, output len, input busy);
  modport ser (input load, input stream, input len, output busy);
endinterface

`default_nettype wire

/* design/plk_req_serializer.sv */
`timescale 1ns/10ps
`default_nettype none

module plk_req_serializer (
  // link clock domain
  input wire logic link_clk_i,
  input wire logic link_reset_i,
  // stream to send
  plk_req_if.ser req,
  // request pin
  output logic request_line_o
);
  logic [plk_pkg::STREAM_W-1:0] shift_reg;
  logic [plk_pkg::STREAM_W-1:0] shift_next;
  logic [plk_pkg::LEN_W-1:0] cnt_reg;
  logic [plk_pkg::LEN_W-1:0] cnt_next;
  logic line_reg;
  logic line_next;

  // busy while bits remain after the one on the line
  assign req.busy = cnt_reg != '0;
  assign request_line_o = line_reg;

  // msb first, one bit per edge, no gaps, line low at rest
  always_comb begin
    shift_next = shift_reg;
    cnt_next = cnt_reg;
    line_next = 1'b0;
    if (req.load && !req.busy) begin
      line_next = req.stream[plk_pkg::STREAM_W-1];
      shift_next = {req.stream[plk_pkg::STREAM_W-2:0], 1'b0};
      cnt_next = req.len - 5'h01;
    end else if (req.busy) begin
      line_next = shift_reg[plk_pkg::STREAM_W-1];
      shift_next = {shift_reg[plk_pkg::STREAM_W-2:0], 1'b0};
      cnt_next = cnt_reg - 5'h01;
    end
  end

  // stream state
  always_ff @(posedge link_clk_i) begin
    if (link_reset_i) begin
      shift_reg <= '0;
      cnt_reg <= '0;
      line_reg <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      cnt_reg <= cnt_next;
      line_reg <= line_next;
    end
  end
endmodule

`default_nettype wire

/* design/plk_link_interface.sv */
`timescale 1ns/10ps
`default_nettype none

module plk_link_interface #(
  parameter bit SHORT_BUS_REQ = 1'b1
) (
  // system clock domain
  input wire logic clk_i,
  input wire logic reset_i,
  // link clock from the phy
  input wire logic phy_interface_clock_i,
  // request command
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic [2:0] req_type_i,
  input wire logic [2:0] req_speed_i,
  input wire logic [3:0] req_addr_i,
  input wire logic [7:0] req_data_i,
  input wire logic req_accel_i,
  output logic req_error_o,
  // bus request outcome
  output logic bus_pending_o,
  output logic bus_won_o,
  output logic bus_lost_o,
  // transmit bytes
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire logic [7:0] tx_byte_i,
  input wire logic tx_last_i,
  input wire logic tx_concat_i,
  // power and isolation
  input wire logic link_power_on_i,
  output logic link_power_indicator_o,
  output logic link_power_state_line_o,
  input wire logic iso_select_i,
  // phy pins
  input wire logic [1:0] control_pair_i,
  output logic [1:0] control_pair_o,
  output logic control_pair_oe_o,
  input wire logic [7:0] phy_data_bus_i,
  output logic [7:0] phy_data_bus_o,
  output logic phy_data_bus_oe_o,
  output logic link_request_line_o
);
  // refuse a stream layout the length counter cannot hold
  if ((1 << plk_pkg::LEN_W) <= plk_pkg::STREAM_W) begin : g_bad_len
    $error("stream length counter too narrow");
  end

  // data lanes carrying data at a speed
  function automatic logic [3:0] lane_width(input logic [2:0] spd);
    case (spd)
      plk_pkg::SPD_S400: lane_width = plk_pkg::LANES_S400;
      plk_pkg::SPD_S200: lane_width = plk_pkg::LANES_S200;
      default: lane_width = plk_pkg::LANES_S100;
    endcase
  endfunction

  // last beat index of a byte at a speed
  function automatic logic [1:0] last_beat(input logic [2:0] spd);
    case (spd)
      plk_pkg::SPD_S400: last_beat = plk_pkg::LAST_BEAT_S400;
      plk_pkg::SPD_S200: last_beat = plk_pkg::LAST_BEAT_S200;
      default: last_beat = plk_pkg::LAST_BEAT_S100;
    endcase
  endfunction

  // request stream image, left aligned, with its length on top
  function automatic logic [21:0] build_stream(input logic [2:0] t, input logic [2:0] s,
      input logic [3:0] a, input logic [7:0] d, input logic acc);
    logic [16:0] bits;
    logic [4:0] len;
    bits = 17'h00000;
    len = plk_pkg::LEN_BUS_LONG;
    case (t)
      plk_pkg::TYPE_REG_READ: begin
        bits = {plk_pkg::START_BIT, t, a, plk_pkg::STOP_BIT, 8'h00};
        len = plk_pkg::LEN_READ;
      end
      plk_pkg::TYPE_REG_WRITE: begin
        bits = {plk_pkg::START_BIT, t, a, d, plk_pkg::STOP_BIT};
        len = plk_pkg::LEN_WRITE;
      end
      plk_pkg::TYPE_ACCEL: begin
        bits = {plk_pkg::START_BIT, t, acc, plk_pkg::STOP_BIT, 11'h000};
        len = plk_pkg::LEN_ACCEL;
      end
      default: begin
        bits = {plk_pkg::START_BIT, t, s, plk_pkg::STOP_BIT, 9'h000};
        len = (SHORT_BUS_REQ && !s[0]) ? plk_pkg::LEN_BUS_SHORT
                                       : plk_pkg::LEN_BUS_LONG;
      end
    endcase
    build_stream = {len, bits};
  endfunction

  // ---------------- system clock domain ----------------
  logic [16:0] rq_stream_reg;
  logic [4:0] rq_len_reg;
  logic rq_tgl_reg;
  logic rq_ack_s1_reg;
  logic rq_ack_s2_reg;
  logic bus_pend_reg;
  logic bus_pend_next;
  logic req_err_reg;
  logic won_s1_reg;
  logic won_s2_reg;
  logic won_seen_reg;
  logic lost_s1_reg;
  logic lost_s2_reg;
  logic lost_seen_reg;
  logic won_pulse_reg;
  logic lost_pulse_reg;
  logic [7:0] tx_byte_hold_reg;
  logic tx_last_hold_reg;
  logic tx_concat_hold_reg;
  logic tx_tgl_reg;
  logic tx_ack_s1_reg;
  logic tx_ack_s2_reg;
  logic power_reg;

  // ---------------- link clock domain ----------------
  logic lrst_s1_reg;
  logic lrst_s2_reg;
  logic iso_s1_reg;
  logic iso_s2_reg;
  logic rq_s1_reg;
  logic rq_s2_reg;
  logic rq_seen_reg;
  logic rq_ack_reg;
  plk_pkg::plk_rq_t rq_state_reg;
  plk_pkg::plk_rq_t rq_state_next;
  logic pend_reg;
  logic pend_next;
  logic [2:0] pend_type_reg;
  logic [2:0] spd_reg;
  logic won_tgl_reg;
  logic lost_tgl_reg;
  logic tx_s1_reg;
  logic tx_s2_reg;
  logic tx_seen_reg;
  plk_pkg::plk_own_t own_reg;
  plk_pkg::plk_own_t own_next;
  logic [7:0] sh_reg;
  logic [7:0] sh_next;
  logic [1:0] beat_reg;
  logic [1:0] beat_next;
  logic last_reg;
  logic last_next;
  logic concat_reg;
  logic concat_next;
  logic tx_take;
  logic [1:0] ctl_out_reg;
  logic ctl_oe_reg;
  logic [7:0] dat_out_reg;
  logic dat_oe_reg;

  // command decode; a held or refused command waits, a bad one is dropped
  wire logic [21:0] rq_image = build_stream(req_type_i, req_speed_i, req_addr_i,
                                            req_data_i, req_accel_i);
  wire logic rq_busy = rq_tgl_reg != rq_ack_s2_reg;
  wire logic req_is_bus = !req_type_i[2];
  wire logic speed_ok = req_speed_i == plk_pkg::SPD_S100 ||
                        req_speed_i == plk_pkg::SPD_S200 ||
                        req_speed_i == plk_pkg::SPD_S400;
  wire logic req_ok = req_type_i != plk_pkg::TYPE_RESERVED &&
                      (!req_is_bus || speed_ok);
  wire logic req_fire = req_valid_i && req_ready_o;
  wire logic req_take = req_fire && req_ok;
  wire logic won_ev = won_s2_reg != won_seen_reg;
  wire logic lost_ev = lost_s2_reg != lost_seen_reg;
  wire logic tx_busy = tx_tgl_reg != tx_ack_s2_reg;

  // a second bus request waits until the first is won or lost
  assign req_ready_o = !rq_busy && !(req_is_bus && bus_pend_reg);
  assign bus_pend_next = (req_take && req_is_bus) ||
                         (bus_pend_reg && !won_ev && !lost_ev);
  assign tx_ready_o = !tx_busy;

  // command capture; held fields stay stable until the link side acks
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rq_stream_reg <= 17'h00000;
      rq_len_reg <= 5'h00;
      rq_tgl_reg <= 1'b0;
      req_err_reg <= 1'b0;
      bus_pend_reg <= 1'b0;
    end else begin
      if (req_take) begin
        rq_stream_reg <= rq_image[16:0];
        rq_len_reg <= rq_image[21:17];
        rq_tgl_reg <= !rq_tgl_reg;
      end
      req_err_reg <= req_fire && !req_ok;
      bus_pend_reg <= bus_pend_next;
    end
  end

  // toggle returns from the link clock domain
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      {rq_ack_s1_reg, rq_ack_s2_reg} <= 2'h0;
      {tx_ack_s1_reg, tx_ack_s2_reg} <= 2'h0;
      {won_s1_reg, won_s2_reg, won_seen_reg} <= 3'h0;
      {lost_s1_reg, lost_s2_reg, lost_seen_reg} <= 3'h0;
    end else begin
      {rq_ack_s1_reg, rq_ack_s2_reg} <= {rq_ack_reg, rq_ack_s1_reg};
      {tx_ack_s1_reg, tx_ack_s2_reg} <= {tx_seen_reg, tx_ack_s1_reg};
      {won_s1_reg, won_s2_reg, won_seen_reg} <= {won_tgl_reg, won_s1_reg, won_s2_reg};
      {lost_s1_reg, lost_s2_reg, lost_seen_reg} <= {lost_tgl_reg, lost_s1_reg, lost_s2_reg};
    end
  end

  // outcome pulses, transmit byte capture and power level
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      won_pulse_reg <= 1'b0;
      lost_pulse_reg <= 1'b0;
      tx_byte_hold_reg <= 8'h00;
      tx_last_hold_reg <= 1'b0;
      tx_concat_hold_reg <= 1'b0;
      tx_tgl_reg <= 1'b0;
      power_reg <= 1'b0;
    end else begin
      won_pulse_reg <= won_ev;
      lost_pulse_reg <= lost_ev;
      if (tx_valid_i && !tx_busy) begin
        tx_byte_hold_reg <= tx_byte_i;
        tx_last_hold_reg <= tx_last_i;
        tx_concat_hold_reg <= tx_concat_i;
        tx_tgl_reg <= !tx_tgl_reg;
      end
      power_reg <= link_power_on_i;
    end
  end

  // reset, isolation select and toggles brought onto the link clock
  always_ff @(posedge phy_interface_clock_i) begin
    lrst_s1_reg <= reset_i;
    lrst_s2_reg <= lrst_s1_reg;
  end

  always_ff @(posedge phy_interface_clock_i) begin
    if (lrst_s2_reg) begin
      {iso_s1_reg, iso_s2_reg} <= 2'h0;
      {rq_s1_reg, rq_s2_reg} <= 2'h0;
      {tx_s1_reg, tx_s2_reg} <= 2'h0;
    end else begin
      {iso_s1_reg, iso_s2_reg} <= {iso_select_i, iso_s1_reg};
      {rq_s1_reg, rq_s2_reg} <= {rq_tgl_reg, rq_s1_reg};
      {tx_s1_reg, tx_s2_reg} <= {tx_tgl_reg, tx_s1_reg};
    end
  end

  // request sender: one stream at a time, acked once fully shifted out
  plk_req_if ser_if ();
  wire logic rq_new = rq_s2_reg != rq_seen_reg;
  wire logic rq_load = rq_state_reg == plk_pkg::RQ_IDLE && rq_new && !ser_if.busy;
  wire logic rq_done = rq_state_reg == plk_pkg::RQ_SEND && !ser_if.busy;
  wire logic [2:0] rq_type = rq_stream_reg[plk_pkg::STREAM_TYPE_LSB +: 3];
  wire logic rq_bus = rq_load && !rq_type[2];
  assign ser_if.load = rq_load;
  assign ser_if.stream = rq_stream_reg;
  assign ser_if.len = rq_len_reg;
  assign rq_state_next = rq_load ? plk_pkg::RQ_SEND :
                         rq_done ? plk_pkg::RQ_IDLE : rq_state_reg;

  plk_req_serializer u_ser (
    .link_clk_i(phy_interface_clock_i),
    .link_reset_i(lrst_s2_reg),
    .req(ser_if),
    .request_line_o(link_request_line_o)
  );

  // bus request outcome as seen on the control pair
  wire logic grant_seen = own_reg == plk_pkg::OWN_PHY &&
                          control_pair_i == plk_pkg::CTL_GRANT;
  wire logic fair_or_pri = pend_type_reg == plk_pkg::TYPE_PRI ||
                           pend_type_reg == plk_pkg::TYPE_FAIR;
  wire logic won_now = pend_reg && grant_seen;
  wire logic lost_now = pend_reg && !won_now && fair_or_pri &&
                        control_pair_i == plk_pkg::CTL_RECEIVE;
  assign pend_next = rq_bus || (pend_reg && !won_now && !lost_now);

  // request and outcome state
  always_ff @(posedge phy_interface_clock_i) begin
    if (lrst_s2_reg) begin
      rq_state_reg <= plk_pkg::RQ_IDLE;
      rq_seen_reg <= 1'b0;
      rq_ack_reg <= 1'b0;
      pend_reg <= 1'b0;
      pend_type_reg <= 3'h0;
      spd_reg <= 3'h0;
      won_tgl_reg <= 1'b0;
      lost_tgl_reg <= 1'b0;
    end else begin
      rq_state_reg <= rq_state_next;
      if (rq_load) rq_seen_reg <= rq_s2_reg;
      if (rq_done) rq_ack_reg <= !rq_ack_reg;
      pend_reg <= pend_next;
      if (rq_bus) begin
        pend_type_reg <= rq_type;
        spd_reg <= rq_stream_reg[plk_pkg::STREAM_SPD_LSB +: 3];
      end
      if (won_now) won_tgl_reg <= !won_tgl_reg;
      if (lost_now) lost_tgl_reg <= !lost_tgl_reg;
    end
  end

  // ownership sequence after a grant; hold while data is late
  wire logic tx_have = tx_s2_reg != tx_seen_reg;
  wire logic byte_end = beat_reg == last_beat(spd_reg);
  wire logic [3:0] lanes = lane_width(spd_reg);

  always_comb begin
    own_next = own_reg;
    sh_next = sh_reg;
    beat_next = beat_reg;
    last_next = last_reg;
    concat_next = concat_reg;
    tx_take = 1'b0;
    case (own_reg)
      plk_pkg::OWN_PHY: begin
        if (grant_seen) own_next = plk_pkg::OWN_HOLD;
      end
      plk_pkg::OWN_HOLD: begin
        if (tx_have) begin
          tx_take = 1'b1;
          own_next = plk_pkg::OWN_XMIT;
        end
      end
      plk_pkg::OWN_XMIT: begin
        if (!byte_end) begin
          sh_next = 8'(sh_reg << lanes);
          beat_next = beat_reg + 2'h1;
        end else if (!last_reg && tx_have) begin
          tx_take = 1'b1;
        end else if (!last_reg || concat_reg) begin
          own_next = plk_pkg::OWN_HOLD;
        end else begin
          own_next = plk_pkg::OWN_RELEASE;
        end
      end
      plk_pkg::OWN_RELEASE: begin
        own_next = plk_pkg::OWN_PHY;
      end
      default: begin
        own_next = plk_pkg::OWN_PHY;
      end
    endcase
    if (tx_take) begin
      sh_next = tx_byte_hold_reg;
      beat_next = 2'h0;
      last_next = tx_last_hold_reg;
      concat_next = tx_concat_hold_reg;
    end
  end

  // pin values follow the next state so they leave flip-flops
  wire logic owning_now = own_reg != plk_pkg::OWN_PHY;
  wire logic owning_next = own_next != plk_pkg::OWN_PHY;
  wire logic [7:0] lane_mask = 8'(8'hFF << (plk_pkg::LANES_ALL - lanes));
  wire logic [1:0] ctl_next = own_next == plk_pkg::OWN_XMIT ? plk_pkg::CTL_XMIT :
                              own_next == plk_pkg::OWN_HOLD ? plk_pkg::CTL_HOLD :
                              plk_pkg::CTL_RELEASE;
  wire logic [7:0] dat_next = own_next == plk_pkg::OWN_XMIT ? (sh_next & lane_mask)
                                                            : 8'h00;
  // isolated links drive only on a change or the first owned cycle;
  // the bus holder keeps the level in between
  wire logic ctl_oe_next = owning_next &&
                           (!iso_s2_reg || !owning_now || ctl_next != ctl_out_reg);
  wire logic dat_oe_next = owning_next &&
                           (!iso_s2_reg || !owning_now || dat_next != dat_out_reg);

  // transmit state and pin drivers
  always_ff @(posedge phy_interface_clock_i) begin
    if (lrst_s2_reg) begin
      own_reg <= plk_pkg::OWN_PHY;
      sh_reg <= 8'h00;
      beat_reg <= 2'h0;
      last_reg <= 1'b0;
      concat_reg <= 1'b0;
      tx_seen_reg <= 1'b0;
      ctl_out_reg <= plk_pkg::CTL_RELEASE;
      ctl_oe_reg <= 1'b0;
      dat_out_reg <= 8'h00;
      dat_oe_reg <= 1'b0;
    end else begin
      own_reg <= own_next;
      sh_reg <= sh_next;
      beat_reg <= beat_next;
      last_reg <= last_next;
      concat_reg <= concat_next;
      if (tx_take) tx_seen_reg <= tx_s2_reg;
      ctl_out_reg <= ctl_next;
      ctl_oe_reg <= ctl_oe_next;
      dat_out_reg <= dat_next;
      dat_oe_reg <= dat_oe_next;
    end
  end

  // outputs
  assign req_error_o = req_err_reg;
  assign bus_pending_o = bus_pend_reg;
  assign bus_won_o = won_pulse_reg;
  assign bus_lost_o = lost_pulse_reg;
  assign link_power_indicator_o = power_reg;
  assign link_power_state_line_o = power_reg;
  assign control_pair_o = ctl_out_reg;
  assign control_pair_oe_o = ctl_oe_reg;
  assign phy_data_bus_o = dat_out_reg;
  assign phy_data_bus_oe_o = dat_oe_reg;
endmodule

`default_nettype wire

/* testbench/plk_link_interface_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module plk_link_interface_asserts (
  // system side
  input wire logic clk_i, reset_i, req_valid_i, req_ready_o, req_error_o,
  input wire logic [2:0] req_type_i, req_speed_i,
  input wire logic bus_pending_o, bus_won_o, bus_lost_o, link_power_on_i, link_power_indicator_o,
  // link side
  input wire logic phy_interface_clock_i, control_pair_oe_o, phy_data_bus_oe_o,
  input wire logic [1:0] control_pair_i, control_pair_o
);
  // commands: bad ones flagged, bus requests kept single
  err_type_a: assert property (@(posedge clk_i) disable iff (reset_i)
    req_valid_i && req_ready_o && req_type_i == 3'h7 |=> req_error_o) else $error("no flag");
  err_speed_a: assert property (@(posedge clk_i) disable iff (reset_i)
    req_valid_i && req_ready_o && !req_type_i[2] && !(req_speed_i inside {3'h0, 3'h2, 3'h4})
    |=> req_error_o) else $error("no flag");
  bus_single_a: assert property (@(posedge clk_i) disable iff (reset_i)
    bus_pending_o && !req_type_i[2] |-> !req_ready_o) else $error("second bus request");
  outcome_clear_a: assert property (@(posedge clk_i) disable iff (reset_i)
    bus_won_o || bus_lost_o |-> $past(bus_pending_o) && !bus_pending_o) else $error("pending");
  power_follow_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !$past(reset_i) |-> link_power_indicator_o == $past(link_power_on_i)) else $error("power");
  // pins: link drives only after a grant and never the reserved code
  ctl_code_a: assert property (@(posedge phy_interface_clock_i) disable iff (reset_i)
    control_pair_oe_o |-> control_pair_o != 2'h3) else $error("reserved code");
  grant_own_a: assert property (@(posedge phy_interface_clock_i) disable iff (reset_i)
    $rose(control_pair_oe_o) |-> $past(control_pair_i) == 2'h3) else $error("no grant");
  data_own_a: assert property (@(posedge phy_interface_clock_i) disable iff (reset_i)
    phy_data_bus_oe_o |-> control_pair_oe_o || $past(control_pair_oe_o)) else $error("data");
  cover property (@(posedge clk_i) bus_won_o);
  cover property (@(posedge clk_i) bus_lost_o);
  cover property (@(posedge clk_i) req_error_o);
endmodule
bind plk_link_interface plk_link_interface_asserts plk_link_interface_asserts_inst (.clk_i,
  .reset_i, .req_valid_i, .req_ready_o, .req_error_o, .req_type_i, .req_speed_i, .bus_pending_o,
  .bus_won_o, .bus_lost_o, .link_power_on_i, .link_power_indicator_o, .phy_interface_clock_i,
  .control_pair_oe_o, .phy_data_bus_oe_o, .control_pair_i, .control_pair_o);
`default_nettype wire

/* testbench/plk_phy_model.sv */
`timescale 1ns/10ps
`default_nettype none
module plk_phy_model (
  // link clock and options
  input wire logic clk_i,
  input wire logic lose_i,
  // link pins
  input wire logic line_i,
  input wire logic [1:0] ctl_i,
  input wire logic ctl_oe_i,
  input wire logic [7:0] data_i,
  // resolved wires
  output logic [1:0] ctl_o,
  output logic [7:0] data_o
);
  logic [16:0] sh;
  logic [1:0] drv = 2'h0;
  logic [7:0] acc;
  logic [2:0] spd = 3'h0;
  logic lost;
  int n = 0, len = 0, gap = 0, k = 0;
  logic [21:0] reqs[$];
  logic [7:0] bytes[$];
  // phy owns both buses unless granted; idle lanes driven low
  assign ctl_o = ctl_oe_i ? ctl_i : drv;
  assign data_o = ctl_oe_i ? data_i : 8'h00;
  // decode streams, arbitrate, collect sent bytes
  always @(posedge clk_i) begin
    drv <= 2'h0; // released: inverse of the grant
    if (gap > 0 && --gap == 0) drv <= lost ? 2'h2 : 2'h3;
    if (n > 0 || line_i === 1'h1) begin
      if (n == 0) sh = 17'h0;
      sh = {sh[15:0], line_i};
      n++;
      if (n == 4) len = !sh[2] ? 7 : sh[1:0] == 2'h0 ? 9 : sh[0] ? 17 : 6;
      if (n == 7 && len == 7) {lost, spd} = {lose_i & sh[4], sh[2:0]};
      if (n == 7 && len == 7 && sh[0]) len = 8;
      if (n == len) begin
        reqs.push_back({n[4:0], sh});
        if (len < 9) gap = len > 6 ? 8 : 0;
        if (len == 9) drv <= 2'h1;
        n = 0;
      end
    end
    if (ctl_oe_i && ctl_i == 2'h2) begin
      acc = (acc << (spd[2] ? 8 : spd[1] ? 4 : 2)) | (data_i >> (spd[2] ? 0 : spd[1] ? 4 : 6));
      k += spd[2] ? 8 : spd[1] ? 4 : 2;
      if (k == 8) bytes.push_back(acc);
      k = k % 8;
    end
  end
endmodule
`default_nettype wire

/* testbench/plk_link_interface_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module plk_link_interface_tb;
  logic clk_i = 1'h0, reset_i = 1'h1, lclk = 1'h0, lose = 1'h0, pwr = 1'h0;
  logic req_valid_i = 1'h0, req_accel_i = 1'h0, tx_valid_i = 1'h0, cat = 1'h0;
  logic [2:0] req_type_i = 3'h0, req_speed_i = 3'h0;
  logic [3:0] req_addr_i = 4'h0;
  logic [7:0] req_data_i = 8'h00, tx_byte_i = 8'h00, bus_d, d_o;
  logic [1:0] ctl, c_o;
  logic req_ready_o, req_error_o, bus_pending_o, bus_won_o, bus_lost_o, tx_ready_o;
  logic pwr_o, link_power_state_line, c_oe, d_oe, line;
  int miscompares = 0, checks_done = 0, won_n = 0, lost_n = 0, err_n = 0;
  // clocks: link clock unrelated in phase
  initial forever #2 clk_i = ~clk_i;
  initial begin
    #7;
    forever #15 lclk = ~lclk;
  end
  plk_link_interface plk_link_interface_inst (.clk_i, .reset_i, .phy_interface_clock_i(lclk),
    .req_valid_i, .req_ready_o, .req_type_i, .req_speed_i, .req_addr_i, .req_data_i,
    .req_accel_i, .req_error_o, .bus_pending_o, .bus_won_o, .bus_lost_o, .tx_valid_i,
    .tx_ready_o, .tx_byte_i, .tx_last_i(1'h1), .tx_concat_i(cat), .link_power_on_i(pwr),
    .link_power_indicator_o(pwr_o), .link_power_state_line_o(link_power_state_line), .iso_select_i(1'h0),
    .control_pair_i(ctl), .control_pair_o(c_o), .control_pair_oe_o(c_oe),
    .phy_data_bus_i(bus_d), .phy_data_bus_o(d_o), .phy_data_bus_oe_o(d_oe),
    .link_request_line_o(line));
  plk_phy_model plk_phy_model_inst (.clk_i(lclk), .lose_i(lose), .line_i(line), .ctl_i(c_o),
    .ctl_oe_i(c_oe), .data_i(d_o), .ctl_o(ctl), .data_o(bus_d));
  // one-cycle pulses are counted so that none is missed
  always @(negedge clk_i) begin
    won_n += int'(bus_won_o === 1'h1);
    lost_n += int'(bus_lost_o === 1'h1);
    err_n += int'(req_error_o === 1'h1);
  end
  task automatic chk(input string nm, input logic [21:0] e, input logic [21:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic send(input logic [2:0] t, s, input logic [3:0] a, input logic [7:0] d);
    {req_valid_i, req_type_i, req_speed_i, req_addr_i, req_data_i} = {1'h1, t, s, a, d};
    req_accel_i = d[0];
    for (int i = 0; i < 3000 && req_ready_o !== 1'h1; i++) @(posedge clk_i) #1;
    @(posedge clk_i) #1 req_valid_i = 1'h0;
    @(posedge clk_i) #1;
  endtask
  task automatic tx(input logic [7:0] b, input logic c = 1'h0);
    {tx_valid_i, tx_byte_i, cat} = {1'h1, b, c};
    for (int i = 0; i < 3000 && tx_ready_o !== 1'h1; i++) @(posedge clk_i) #1;
    @(posedge clk_i) #1 tx_valid_i = 1'h0;
  endtask
  // waits for a decoded stream (b=0) or a sent byte (b=1)
  task automatic take(input bit b, input logic [21:0] e);
    logic [21:0] v;
    for (int i = 0; i < 3000 && (b ? plk_phy_model_inst.bytes.size()
        : plk_phy_model_inst.reqs.size()) == 0; i++) @(posedge clk_i) #1;
    v = 22'h3FFFFF;
    if (b && plk_phy_model_inst.bytes.size() > 0) v = 22'(plk_phy_model_inst.bytes.pop_front());
    if (!b && plk_phy_model_inst.reqs.size() > 0) v = plk_phy_model_inst.reqs.pop_front();
    chk(b ? "byte" : "stream", e, v);
  endtask
  task automatic t_regs;
    send(3'h4, 3'h0, 4'h5, 8'h00);
    take(0, {5'h09, 8'h00, 1'h1, 3'h4, 4'h5, 1'h0});
    send(3'h5, 3'h0, 4'hA, 8'h3C);
    take(0, {5'h11, 1'h1, 3'h5, 4'hA, 8'h3C, 1'h0});
    for (int b = 0; b < 2; b++) begin
      send(3'h6, 3'h0, 4'h0, 8'(b));
      take(0, {5'h06, 11'h000, 1'h1, 3'h6, 1'(b), 1'h0});
    end
  endtask
  // every bus request type and speed; priority byte comes late, so the link holds
  task automatic t_bus;
    for (int t = 0; t < 4; t++) begin
      if (t != 2) tx(8'hA5 ^ 8'(t), 1'(t == 1));
      send(3'(t), 3'(t == 3 ? 0 : t * 2), 4'h0, 8'h00);
      take(0, {5'h07, 10'h000, 1'h1, 3'(t), 3'(t == 3 ? 0 : t * 2)});
      if (t == 2) repeat (100) @(posedge clk_i) #1;
      if (t == 2) chk("hold", 22'h00D, {10'h0, d_o, d_oe, c_oe, c_o});
      if (t == 2) tx(8'hA7);
      take(1, {14'h0, 8'hA5 ^ 8'(t)});
      chk("won", 22'(t + 1), 22'(won_n));
      if (t == 1) chk("concat", 22'h00D, {10'h0, d_o, d_oe, c_oe, c_o});
      if (t == 1) tx(8'h5A);
      if (t == 1) take(1, 22'h5A);
    end
  endtask
  task automatic t_bad;
    send(3'h7, 3'h0, 4'h0, 8'h00);
    send(3'h3, 3'h1, 4'h0, 8'h00);
    repeat (200) @(posedge clk_i) #1;
    chk("error", 22'h2, 22'(err_n));
    chk("dropped", 22'h0, 22'(plk_phy_model_inst.reqs.size()));
  endtask
  task automatic t_lost;
    lose = 1'h1;
    send(3'h3, 3'h4, 4'h0, 8'h00);
    take(0, {5'h07, 10'h000, 1'h1, 3'h3, 3'h4});
    repeat (25) @(posedge clk_i) #1;
    chk("pending", 22'h2, {20'h0, bus_pending_o, req_ready_o});
    for (int i = 0; i < 300 && lost_n == 0; i++) @(posedge clk_i) #1;
    chk("lost", 22'h1, 22'(lost_n));
    lose = 1'h0;
  endtask
  task automatic print_verdict;
    $display("miscompares %0d checks_done %0d", miscompares, checks_done);
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // link domain needs several of its own edges inside reset
  initial begin
    repeat (32) @(posedge clk_i) #1;
    {reset_i, pwr} = 2'h1;
    t_regs();
    t_bus();
    t_bad();
    t_lost();
    chk("power", 22'h3, {20'h0, pwr_o, link_power_state_line});
    print_verdict();
  end
  initial begin
    #200000;
    miscompares++;
    print_verdict();
  end
endmodule
`default_nettype wire
